// ---- verilog/load_store_instruction_unit.sv ----
// Execution unit for data-transfer and core-control instructions.
// Assumes decode presents one op with ISSUE for one cycle while READY is
// high; data memory reads return data in the same cycle as the read strobe.
module load_store_instruction_unit
    import lsu_pkg::*;
(
    input wire logic MCLK,              // Core clock, 100 MHz
    input wire logic SYS_RST,           // Synchronous reset, active high
    input wire logic ISSUE,             // Decode presents an op this cycle
    input wire op_t OP,                 // Operation code
    input wire logic [1:0] PTR_SEL,     // X, Y or Z pointer
    input wire logic [4:0] REG_ADDR,    // Destination or source register
    input wire logic PM_IMPLICIT,       // Program read without operand
    input wire logic PM_POSTINC,        // Program read with Z+
    input wire logic [5:0] DISP,        // Displacement offset
    input wire logic [15:0] ABS_ADDR,   // Absolute address word
    input wire logic [7:0] SOURCE_REGISTER, // Source register value
    input wire logic [15:0] PTR_X_IN,   // X pointer from register file
    input wire logic [15:0] PTR_Y_IN,   // Y pointer from register file
    input wire logic [15:0] PTR_Z_IN,   // Z pointer from register file
    input wire logic [15:0] SP_IN,      // Stack pointer
    input wire logic [7:0] DM_RDATA,    // Data memory read data
    input wire logic [7:0] PM_RDATA,    // Program memory byte
    input wire logic DEBUG_EN,          // On-chip debug enabled
    output logic READY,                 // Unit can take an op
    output logic DM_RD,                 // Data memory read strobe
    output logic DM_WR,                 // Data memory write strobe
    output logic [15:0] DM_ADDR,        // Data memory address
    output logic [7:0] DM_WDATA,        // Data memory write data
    output logic PM_RD,                 // Program memory read strobe
    output logic [15:0] PM_ADDR,        // Program memory byte address
    output logic RF_WE,                 // Register file byte write
    output logic [4:0] RF_WADDR,        // Register being written
    output logic [7:0] RF_WDATA,        // Byte written
    output logic PTR_WE,                // Pointer pair write
    output logic [1:0] PTR_WSEL,        // Which pointer is written
    output logic [15:0] PTR_WDATA,      // New pointer value
    output logic SP_WE,                 // Stack pointer write
    output logic [15:0] SP_WDATA,       // New stack pointer
    output logic SLEEP_REQ,             // Pulse to sleep-mode logic
    output logic BREAK_REQ              // Pulse to debug facility
);
    // Op classes as seen by the sequencer
    typedef enum {
        ST_IDLE,   // Waiting for an op
        ST_LOAD,   // Data read in flight
        ST_STORE,  // Store finishing
        ST_PMEM    // Program read in flight
    } state_t;

    state_t state_reg;        // Sequencer state
    logic take;               // Op accepted this cycle
    logic [15:0] ptr_sel_val; // Selected pointer
    logic [15:0] eff_addr;    // Computed address
    logic [15:0] ptr_new;     // Updated pointer
    logic [15:0] sp_new;      // Updated stack pointer
    logic [1:0] cycles;       // Cycle count of the accepted op
    logic busy;               // Timer says instruction in flight
    logic last;               // Final cycle of the instruction
    logic is_load;            // Loads and pop
    logic is_store;           // Stores and push
    logic ptr_update;         // Op changes a pointer
    logic [4:0] dest_reg;     // Latched destination

    assign take = ISSUE && READY;

    // Pointer mux; Z is forced for program reads
    always_comb begin
        if (OP == OP_PM_READ || PTR_SEL == PTR_Z) begin
            ptr_sel_val = PTR_Z_IN;
        end else if (PTR_SEL == PTR_Y) begin
            ptr_sel_val = PTR_Y_IN;
        end else begin
            ptr_sel_val = PTR_X_IN;
        end
    end

    lsu_addr_gen u_addr (
        .op(OP),
        .ptr(ptr_sel_val),
        .disp(DISP),
        .abs_addr(ABS_ADDR),
        .sp(SP_IN),
        .eff_addr(eff_addr),
        .ptr_new(ptr_new),
        .sp_new(sp_new)
    );

    // Op classification
    always_comb begin
        is_load = 1'b0;
        is_store = 1'b0;
        ptr_update = 1'b0;
        cycles = 2'(DATA_CYCLES);
        case (OP)
            OP_LD_PLAIN, OP_LD_DISP, OP_LD_ABS, OP_POP: begin
                is_load = 1'b1;
            end
            OP_LD_POSTINC, OP_LD_PREDEC: begin
                is_load = 1'b1;
                ptr_update = 1'b1;
            end
            OP_ST_PLAIN, OP_ST_DISP, OP_ST_ABS, OP_PUSH: begin
                is_store = 1'b1;
            end
            OP_ST_POSTINC, OP_ST_PREDEC: begin
                is_store = 1'b1;
                ptr_update = 1'b1;
            end
            OP_PM_READ: begin
                cycles = 2'(PM_CYCLES);
                ptr_update = PM_POSTINC && !PM_IMPLICIT;
            end
            default: begin
                cycles = 2'(SLEEP_CYCLES);
            end
        endcase
    end

    // Cycle timer; not started for one-cycle ops
    lsu_cycle_timer u_timer (
        .clk(MCLK),
        .rst(SYS_RST),
        .start(take && cycles != 2'h1),
        .cycles(cycles),
        .busy(busy),
        .last(last)
    );

    // Sequencer state
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            state_reg <= ST_IDLE;
        end else if (take && is_load) begin
            state_reg <= ST_LOAD;
        end else if (take && is_store) begin
            state_reg <= ST_STORE;
        end else if (take && OP == OP_PM_READ) begin
            state_reg <= ST_PMEM;
        end else if (last) begin
            state_reg <= ST_IDLE;
        end
    end

    // Ready drops while a multi-cycle op runs
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            READY <= 1'b1;
        end else if (take && cycles != 2'h1) begin
            READY <= 1'b0;
        end else if (last) begin
            READY <= 1'b1;
        end
    end

    // Memory strobes and address, issued in the first cycle
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            DM_RD <= 1'b0;
            DM_WR <= 1'b0;
            DM_ADDR <= 16'h0000;
            DM_WDATA <= 8'h00;
            PM_RD <= 1'b0;
            PM_ADDR <= 16'h0000;
        end else begin
            DM_RD <= take && is_load;
            DM_WR <= take && is_store;
            PM_RD <= take && OP == OP_PM_READ;
            if (take) begin
                DM_ADDR <= eff_addr;
                DM_WDATA <= SOURCE_REGISTER;
                PM_ADDR <= PTR_Z_IN; // Program read uses pre-update Z
            end
        end
    end

    // Latch destination; operand-less program read targets R0
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            dest_reg <= 5'h00;
        end else if (take) begin
            dest_reg <= (OP == OP_PM_READ && PM_IMPLICIT) ? REG_R0 : REG_ADDR;
        end
    end

    // Register file write in the final cycle; flags never touched
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            RF_WE <= 1'b0;
            RF_WADDR <= 5'h00;
            RF_WDATA <= 8'h00;
        end else begin
            RF_WE <= last && (state_reg == ST_LOAD || state_reg == ST_PMEM);
            RF_WADDR <= dest_reg;
            RF_WDATA <= (state_reg == ST_PMEM) ? PM_RDATA : DM_RDATA;
        end
    end

    // Pointer and stack pointer write-back, one cycle after acceptance
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PTR_WE <= 1'b0;
            PTR_WSEL <= PTR_X;
            PTR_WDATA <= PTR_RESET;
            SP_WE <= 1'b0;
            SP_WDATA <= SP_RESET;
        end else begin
            PTR_WE <= take && ptr_update;
            SP_WE <= take && (OP == OP_PUSH || OP == OP_POP);
            if (take) begin
                PTR_WSEL <= (OP == OP_PM_READ) ? PTR_Z : PTR_SEL;
                PTR_WDATA <= ptr_new;
                SP_WDATA <= sp_new;
            end
        end
    end

    // Sleep and break are single pulses to their own logic
    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            SLEEP_REQ <= 1'b0;
            BREAK_REQ <= 1'b0;
        end else begin
            SLEEP_REQ <= take && OP == OP_SLEEP;
            // Without debug enabled the break acts as nothing
            BREAK_REQ <= take && OP == OP_BREAK && DEBUG_EN;
        end
    end
endmodule

// ---- inc/lsu_pkg.sv ----
// Constants and types shared by the load/store execution unit.
// Assumes a single 100 MHz core clock and byte-wide data memory.
package lsu_pkg;
    // Operation codes handed over by the decode path
    typedef enum logic [3:0] {
        OP_NONE,        // Nothing to do
        OP_LD_PLAIN,    // Indirect load, pointer untouched
        OP_LD_POSTINC,  // Indirect load, then pointer + 1
        OP_LD_PREDEC,   // Pointer - 1, then indirect load
        OP_LD_DISP,     // Load at pointer + offset
        OP_LD_ABS,      // Load at absolute address
        OP_ST_PLAIN,    // Indirect store
        OP_ST_POSTINC,  // Indirect store, then pointer + 1
        OP_ST_PREDEC,   // Pointer - 1, then indirect store
        OP_ST_DISP,     // Store at pointer + offset
        OP_ST_ABS,      // Store at absolute address
        OP_PM_READ,     // Program memory byte read
        OP_PUSH,        // Stack push
        OP_POP,         // Stack pop
        OP_SLEEP,       // Enter sleep
        OP_BREAK        // Debug break
    } op_t;

    // Pointer selectors
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    // Cycle counts per instruction class
    localparam int DATA_CYCLES = 2;
    localparam int PM_CYCLES = 3;
    localparam int SLEEP_CYCLES = 1;

    // Register file slot for the operand-less program memory read
    localparam logic [4:0] REG_R0 = 5'h00;

    // Reset values
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'hffff;
endpackage

// ---- verilog/lsu_addr_gen.sv ----
// Effective address and pointer update for indirect/absolute/stack ops.
// Pure combinational; the caller registers the results.
module lsu_addr_gen
    import lsu_pkg::*;
(
    input wire op_t op,              // Operation being started
    input wire logic [15:0] ptr,     // Selected pointer value
    input wire logic [5:0] disp,     // Displacement offset
    input wire logic [15:0] abs_addr, // Absolute address word
    input wire logic [15:0] sp,      // Stack pointer
    output logic [15:0] eff_addr,    // Address to access
    output logic [15:0] ptr_new,     // Pointer after the op
    output logic [15:0] sp_new       // Stack pointer after the op
);
    logic [15:0] ptr_inc;  // Wraps modulo 2^16
    logic [15:0] ptr_dec;  // Wraps modulo 2^16

    assign ptr_inc = ptr + 16'h0001;
    assign ptr_dec = ptr - 16'h0001;

    // Address selection per operation class
    always_comb begin
        eff_addr = ptr;
        ptr_new = ptr;
        sp_new = sp;
        case (op)
            OP_LD_POSTINC, OP_ST_POSTINC: begin
                ptr_new = ptr_inc;
            end
            OP_LD_PREDEC, OP_ST_PREDEC: begin
                eff_addr = ptr_dec;
                ptr_new = ptr_dec;
            end
            OP_LD_DISP, OP_ST_DISP: begin
                eff_addr = ptr + {10'h000, disp};
            end
            OP_LD_ABS, OP_ST_ABS: begin
                eff_addr = abs_addr;
            end
            OP_PM_READ: begin
                ptr_new = ptr_inc; // Used only for the post-increment form
            end
            OP_PUSH: begin
                eff_addr = sp; // Write then decrement
                sp_new = sp - 16'h0001;
            end
            OP_POP: begin
                eff_addr = sp + 16'h0001; // Increment then read
                sp_new = sp + 16'h0001;
            end
            default: begin
                eff_addr = ptr;
            end
        endcase
    end
endmodule

// ---- verilog/lsu_cycle_timer.sv ----
// Down-counter that holds the unit busy for an instruction's cycle count.
// Loads on start; last pulses in the instruction's final cycle for a count of 2 or 3, never for 1.
module lsu_cycle_timer (
    input wire logic clk,          // Core clock
    input wire logic rst,          // Synchronous reset, high
    input wire logic start,        // Load a new count
    input wire logic [1:0] cycles, // Total cycles, 1..3
    output logic busy,             // Instruction in flight
    output logic last              // Final cycle of the instruction
);
    logic [1:0] left_reg; // Cycles still to go, this one included

    // Count down; zero means idle
    always_ff @(posedge clk) begin
        if (rst) begin
            left_reg <= 2'h0;
        end else if (start) begin
            left_reg <= cycles - 2'h1;
        end else if (left_reg != 2'h0) begin
            left_reg <= left_reg - 2'h1;
        end
    end

    assign busy = (left_reg != 2'h0);
    assign last = (left_reg == 2'h1);
endmodule

// ---- verification/load_store_instruction_unit_checker.sv ----
// Concurrent checks on the load/store unit's cycle timing and strobes.
// Sees only top-level ports; bound onto every instance of the unit.
module lsu_checker
    import lsu_pkg::*;
(
    input wire logic MCLK,              // Core clock
    input wire logic SYS_RST,           // Sync reset, high
    input wire logic ISSUE,             // Op offered
    input wire op_t OP,                 // Op code
    input wire logic [1:0] PTR_SEL,     // Pointer select
    input wire logic [15:0] PTR_Y_IN,   // Y pointer now
    input wire logic DEBUG_EN,          // Debug enabled
    input wire logic READY,             // Unit free
    input wire logic DM_RD,             // Data read
    input wire logic DM_WR,             // Data write
    input wire logic PM_RD,             // Program read
    input wire logic RF_WE,             // Register write
    input wire logic PTR_WE,            // Pointer write
    input wire logic [15:0] PTR_WDATA,  // New pointer
    input wire logic SP_WE,             // Stack pointer write
    input wire logic SLEEP_REQ,         // Sleep pulse
    input wire logic BREAK_REQ          // Break pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    wire logic taken = ISSUE && READY; // Op accepted on this edge
    // Load tail: busy one cycle, then free with the register write
    sequence load_end;
        !READY ##1 (READY && RF_WE);
    endsequence
    // Store tail: busy one cycle, then free with no second write
    sequence free_next;
        !READY ##1 (READY && !DM_WR);
    endsequence
    load_timing_a: assert property (
        taken && OP inside {[OP_LD_PLAIN:OP_LD_ABS]} |=> DM_RD ##0 load_end)
        else $error("load timing wrong");
    store_timing_a: assert property (
        taken && OP inside {[OP_ST_PLAIN:OP_ST_ABS]} |=> DM_WR ##0 free_next)
        else $error("store timing wrong");
    progread_timing_a: assert property (
        taken && OP == OP_PM_READ |=> PM_RD && !READY ##1 !READY && !RF_WE ##1 READY && RF_WE)
        else $error("program read timing wrong");
    push_stack_a: assert property (
        taken && OP == OP_PUSH |=> DM_WR && SP_WE ##0 free_next)
        else $error("push timing wrong");
    pop_stack_a: assert property (
        taken && OP == OP_POP |=> DM_RD && SP_WE ##0 load_end)
        else $error("pop timing wrong");
    sleep_pulse_a: assert property (
        taken && OP == OP_SLEEP |=> SLEEP_REQ && READY)
        else $error("sleep pulse wrong");
    break_gate_a: assert property (
        taken && OP == OP_BREAK |=> BREAK_REQ == $past(DEBUG_EN))
        else $error("break gating wrong");
    postinc_wrap_a: assert property (
        taken && OP == OP_LD_POSTINC && PTR_SEL == PTR_Y
        |=> PTR_WE && PTR_WDATA == $past(PTR_Y_IN) + 16'h0001)
        else $error("pointer increment wrong");
endmodule

bind load_store_instruction_unit lsu_checker u_lsu_checker (.MCLK, .SYS_RST, .ISSUE, .OP,
    .PTR_SEL, .PTR_Y_IN, .DEBUG_EN, .READY, .DM_RD, .DM_WR, .PM_RD, .RF_WE, .PTR_WE,
    .PTR_WDATA, .SP_WE, .SLEEP_REQ, .BREAK_REQ);

// ---- verification/lsu_mem_model.sv ----
// Far-side memory model: data and program bytes from an address hash.
// Assumes data bytes are looked at up to one cycle after the strobe, program bytes up to two.
module lsu_mem_model (
    input wire logic MCLK,           // Core clock
    input wire logic DM_RD,          // Data read strobe
    input wire logic [15:0] DM_ADDR, // Data address
    input wire logic PM_RD,          // Program read strobe
    input wire logic [15:0] PM_ADDR, // Program address
    output logic [7:0] DM_RDATA,     // Data byte
    output logic [7:0] PM_RDATA      // Program byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic dm_hold_reg = 1'b0;        // Data window still open
    logic [1:0] pm_hold_reg = 2'h0;  // Program window stages
    logic [7:0] junk_reg = 8'h00;    // Changes every cycle
    // Windows close and junk moves on every edge
    always_ff @(posedge MCLK) begin
        dm_hold_reg <= DM_RD;
        pm_hold_reg <= {pm_hold_reg[0], PM_RD};
        junk_reg <= junk_reg + 8'h35;
    end
    // Outside the window the bus shows junk, so stale data never matches by luck
    assign DM_RDATA = (DM_RD || dm_hold_reg) ? DM_ADDR[7:0] ^ DM_ADDR[15:8] ^ 8'h5a : junk_reg;
    assign PM_RDATA = (PM_RD || |pm_hold_reg) ? PM_ADDR[7:0] + PM_ADDR[15:8] + 8'h1c : junk_reg;
endmodule

// ---- verification/test_load_store_instruction_unit.sv ----
// Self-checking bench for the load/store unit: corner sweep, then LFSR ops.
// Assumes the memory model answers reads; ops are issued back to back.
module test_load_store_instruction_unit import lsu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, SYS_RST = 1'b1, ISSUE = 1'b0, DEBUG_EN = 1'b0; // Control inputs
    logic PM_IMPLICIT = 1'b0, PM_POSTINC = 1'b0; // Program read forms
    op_t OP = OP_NONE; // Op code
    logic [1:0] PTR_SEL = PTR_X; // Pointer select
    logic [4:0] REG_ADDR = 5'h00; // Register index
    logic [5:0] DISP = 6'h00; // Offset
    logic [7:0] SOURCE_REGISTER = 8'h00; // Store data
    logic [15:0] ABS_ADDR = 16'h0000, PTR_X_IN = 16'h0000, PTR_Y_IN = 16'h0000;
    logic [15:0] PTR_Z_IN = 16'h0000, SP_IN = 16'h0000; // Pointer values
    logic READY, DM_RD, DM_WR, PM_RD, RF_WE, PTR_WE, SP_WE, SLEEP_REQ, BREAK_REQ;
    logic [7:0] DM_RDATA, PM_RDATA, DM_WDATA, RF_WDATA; // Byte buses
    logic [15:0] DM_ADDR, PM_ADDR, PTR_WDATA, SP_WDATA; // Word buses
    logic [4:0] RF_WADDR; // Written register
    logic [1:0] PTR_WSEL; // Written pointer
    int num_errors = 0, comparisons = 0, cycles = 0; // Tallies
    logic [15:0] lfsr = 16'h002a; // Random source, fixed start

    load_store_instruction_unit u_load_store_instruction_unit (.MCLK, .SYS_RST, .ISSUE, .OP,
        .PTR_SEL, .REG_ADDR, .PM_IMPLICIT, .PM_POSTINC, .DISP, .ABS_ADDR, .SOURCE_REGISTER,
        .PTR_X_IN, .PTR_Y_IN, .PTR_Z_IN, .SP_IN, .DM_RDATA, .PM_RDATA, .DEBUG_EN, .READY,
        .DM_RD, .DM_WR, .DM_ADDR, .DM_WDATA, .PM_RD, .PM_ADDR, .RF_WE, .RF_WADDR, .RF_WDATA,
        .PTR_WE, .PTR_WSEL, .PTR_WDATA, .SP_WE, .SP_WDATA, .SLEEP_REQ, .BREAK_REQ);
    lsu_mem_model u_lsu_mem_model (.MCLK, .DM_RD, .DM_ADDR, .PM_RD, .PM_ADDR, .DM_RDATA,
        .PM_RDATA);

    // Free-running core clock
    initial forever #5 MCLK = ~MCLK;

    // Next LFSR value
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // Expected bytes, same hash as the memories hold
    function automatic logic [7:0] dm_exp(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    function automatic logic [7:0] pm_exp(input logic [15:0] a);
        return a[7:0] + a[15:8] + 8'h1c;
    endfunction

    // One comparison; unknowns never match
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the roughly 1200 cycles the run needs
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            test_done();
        end
    end

    // Issue one op at a falling edge and follow it to its last cycle
    task automatic exec(input op_t o, input logic refuse);
        logic rd, wr, pm, pwe, swe, rfw;
        logic [15:0] p, ea, np, nsp;
        int n;
        pm = (o == OP_PM_READ);
        p = pm ? PTR_Z_IN : (PTR_SEL == PTR_X) ? PTR_X_IN : (PTR_SEL == PTR_Y) ? PTR_Y_IN : PTR_Z_IN;
        rd = (o inside {[OP_LD_PLAIN:OP_LD_ABS], OP_POP});
        wr = (o inside {[OP_ST_PLAIN:OP_ST_ABS], OP_PUSH});
        pwe = (o inside {OP_LD_POSTINC, OP_LD_PREDEC, OP_ST_POSTINC, OP_ST_PREDEC})
              || (pm && PM_POSTINC && !PM_IMPLICIT);
        swe = (o inside {OP_PUSH, OP_POP});
        rfw = rd || pm;
        n = pm ? 3 : (rd || wr) ? 2 : 1;
        np = (o inside {OP_LD_PREDEC, OP_ST_PREDEC}) ? p - 16'h0001 : p + 16'h0001;
        nsp = (o == OP_PUSH) ? SP_IN - 16'h0001 : SP_IN + 16'h0001;
        case (o)
            OP_LD_PREDEC, OP_ST_PREDEC: ea = np;
            OP_LD_DISP, OP_ST_DISP: ea = p + {10'h000, DISP};
            OP_LD_ABS, OP_ST_ABS: ea = ABS_ADDR;
            OP_PUSH: ea = SP_IN;
            OP_POP: ea = nsp;
            default: ea = p;
        endcase
        OP = o;
        ISSUE = 1'b1;
        check(READY, 1'b1);
        @(negedge MCLK);
        // A refused offer is held through the first busy cycle
        if (n > 1) ISSUE = refuse;
        check(DM_RD, rd);
        check(DM_WR, wr);
        check(PM_RD, pm);
        check(PTR_WE, pwe);
        check(SP_WE, swe);
        check(SLEEP_REQ, o == OP_SLEEP);
        check(BREAK_REQ, o == OP_BREAK && DEBUG_EN);
        check(READY, n == 1);
        check(RF_WE, 1'b0);
        if (rd || wr) check(DM_ADDR, ea);
        if (wr) check(DM_WDATA, SOURCE_REGISTER);
        if (pm) check(PM_ADDR, p);
        if (pwe) check(PTR_WDATA, np);
        if (pwe) check(PTR_WSEL, pm ? PTR_Z : PTR_SEL);
        if (swe) check(SP_WDATA, nsp);
        for (int k = 2; k <= n; k++) begin
            @(negedge MCLK);
            if (k < n) ISSUE = 1'b0;
            check({DM_RD, DM_WR, PM_RD, SP_WE}, 4'h0);
            check(READY, k == n);
            check(RF_WE, rfw && k == n);
        end
        if (rfw) check(RF_WADDR, (pm && PM_IMPLICIT) ? REG_R0 : REG_ADDR);
        if (rfw) check(RF_WDATA, pm ? pm_exp(p) : dm_exp(ea));
    endtask

    // Main sequence: reset, corner sweep of every op, then random ops
    initial begin
        repeat (2) @(negedge MCLK);
        SYS_RST = 1'b0;
        check(READY, 1'b1);
        check(PTR_WDATA, PTR_RESET);
        check(SP_WDATA, SP_RESET);
        // Pointers at both ends of the range; three program read forms
        for (int c = 0; c < 3; c++) begin
            PTR_SEL = 2'(c);
            {PTR_X_IN, PTR_Y_IN, PTR_Z_IN, SP_IN, ABS_ADDR} = {5{(c == 1) ? 16'hffff : 16'h0000}};
            {DISP, REG_ADDR, SOURCE_REGISTER} = {6'h3f, 5'h1f, 8'ha5};
            {PM_IMPLICIT, PM_POSTINC, DEBUG_EN} = {c == 1, c != 0, c != 2};
            for (int i = 0; i < 16; i++) exec(op_t'(4'(i)), c == 1);
        end
        repeat (600) begin
            PTR_SEL = 2'(rnd() % 3);
            {PTR_X_IN, PTR_Y_IN, PTR_Z_IN, SP_IN, ABS_ADDR} = {rnd(), rnd(), rnd(), rnd(), rnd()};
            {DISP, REG_ADDR, SOURCE_REGISTER} = 19'({rnd(), rnd()});
            {PM_IMPLICIT, PM_POSTINC, DEBUG_EN} = 3'(rnd());
            exec(op_t'(4'(rnd())), rnd() % 4 == 0);
        end
        ISSUE = 1'b0;
        repeat (3) @(negedge MCLK);
        test_done();
    end
endmodule
